// ### rtl/sar_adc_ctrl.sv
module sar_adc_ctrl (
  input  wire logic                  ref_clk,      // 100 MHz clock
  input  wire logic                  sys_rst,      // Sync reset, high
  input  wire logic                  convert_cmd,  // Convert command
  input  wire sar_pkg::coding_t      coding_sel,   // Static coding mode
  input  wire logic                  cmp_keep,     // Comparator: input > trial
  output logic      [15:0]           trial_word,   // Word to internal DAC
  output logic                       status,       // Busy, high in conversion
  output logic                       msb_true,     // Top bit, true form
  output logic                       msb_inv,      // Top bit, inverted form
  output logic      [14:0]           data_low      // Remaining result bits
);
  typedef struct packed {
    sar_pkg::state_t st;
    logic            cmd_q;
    logic [4:0]      bit_q;
    logic [2:0]      tick_q;
    sar_pkg::coding_t coding_q;
  } ctrl_t;

  ctrl_t       s_q;
  ctrl_t       s_d;
  logic        start_edge;
  logic        load;
  logic        step;
  logic [15:0] word_q;

  // Decoded in several places; keeps the state compare in one spot
  function automatic logic is_busy(input sar_pkg::state_t st);
    return st == sar_pkg::ST_CONV;
  endfunction

  // Comparator sense: bit kept when input is above trial
  assign start_edge = s_q.cmd_q & ~convert_cmd;
  assign load       = start_edge && !is_busy(s_q.st);
  assign step       = is_busy(s_q.st)
                      && (s_q.tick_q == sar_pkg::LAST_TICK);

  always_comb begin
    s_d       = s_q;
    s_d.cmd_q = convert_cmd;
    unique case (s_q.st)
      sar_pkg::ST_IDLE: begin
        if (load) begin
          s_d.st     = sar_pkg::ST_CONV;
          s_d.bit_q  = sar_pkg::LAST_BIT;
          s_d.tick_q = '0;
          // Coding is captured so a change mid-conversion can be seen
          s_d.coding_q = coding_sel;
        end
      end
      sar_pkg::ST_CONV: begin
        s_d.tick_q = s_q.tick_q + 3'h1;
        if (step) begin
          if (s_q.bit_q == 5'h00) begin
            s_d.st = sar_pkg::ST_IDLE;
          end else begin
            s_d.bit_q = s_q.bit_q - 5'h01;
          end
        end
      end
      default: begin
        s_d.st = sar_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q.st     <= sar_pkg::ST_IDLE;
      s_q.cmd_q  <= 1'b0;
      s_q.bit_q  <= '0;
      s_q.tick_q <= '0;
      s_q.coding_q <= sar_pkg::CODE_STRAIGHT;
    end else begin
      s_q <= s_d;
    end
  end

  sar_bit_reg u_sar (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (load),
    .step    (step),
    .bit_idx (s_q.bit_q[3:0]),
    .keep    (cmp_keep),
    .word_q  (word_q)
  );

  // Straight and offset binary share one word; two's complement only
  // flips the top bit, so the converter core never changes.
  assign trial_word = word_q;
  assign status     = is_busy(s_q.st);
  assign msb_true   = word_q[15];
  assign msb_inv    = ~word_q[15];
  assign data_low   = word_q[14:0];

  // Bounds: 16 bits of 8 ticks, well below the 35 us ceiling
  localparam int CONV_CYC = sar_pkg::RES_BITS * sar_pkg::BIT_CYC;

  sequence s_start;
    (s_q.st == sar_pkg::ST_IDLE) && s_q.cmd_q && !convert_cmd;
  endsequence

  sequence s_busy;
    status [*8];
  endsequence

  // Seven quiet ticks between two bit decisions
  sequence s_gap;
    (!step) [*7];
  endsequence

  sequence s_last;
    step && (s_q.bit_q == 5'h00);
  endsequence

  a_start_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_start |=> s_busy)
    else $error("status not raised after start edge");

  a_start_code: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_start |=> (word_q == sar_pkg::START_CODE))
    else $error("start code wrong");

  a_conv_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(status) |-> ##[CONV_CYC:CONV_CYC] $fell(status))
    else $error("conversion length wrong");

  a_msb_pair: assert property (@(posedge ref_clk) disable iff (sys_rst)
    msb_inv != msb_true)
    else $error("inverted top bit mismatch");

  a_hold_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!status && !load) |=> $stable(word_q))
    else $error("result changed while idle");

  a_no_retrig: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (status && s_q.bit_q != sar_pkg::LAST_BIT) |=>
      (s_q.bit_q != sar_pkg::LAST_BIT || !status))
    else $error("conversion retriggered");

  a_bit_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (step && s_q.bit_q != 5'h00) |=>
      (s_q.bit_q == $past(s_q.bit_q) - 5'h01))
    else $error("bit order wrong");

  a_bit_decide: assert property (@(posedge ref_clk) disable iff (sys_rst)
    step |=> (word_q[$past(s_q.bit_q[3:0])] == $past(cmp_keep)))
    else $error("bit decision not stored");

  a_coding_static: assert property (@(posedge ref_clk) disable iff (sys_rst)
    status |-> (coding_sel == s_q.coding_q))
    else $error("coding changed during conversion");

  a_step_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    step |=> s_gap)
    else $error("bit decisions too close");

  a_last_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_last |=> !status)
    else $error("status not dropped after last bit");

  // A retrigger would reload the word or the bit index mid-slot
  a_busy_freeze: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (status && !step) |=> ($stable(word_q) && $stable(s_q.bit_q)))
    else $error("word moved between decisions");

  a_trial_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (step && (s_q.bit_q != 5'h00)) |=>
      (word_q[$past(s_q.bit_q[3:0]) - 4'h1] == 1'b0))
    else $error("next trial bit not cleared");

  a_tick_run: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (status && !step) |=>
      (s_q.tick_q == $past(s_q.tick_q) + 3'h1))
    else $error("tick counter skipped");

  // Idle tick at zero keeps the first slot a full eight cycles
  a_idle_tick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !status |-> (s_q.tick_q == 3'h0))
    else $error("tick counter not parked");

  a_status_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(status) |-> $past(load))
    else $error("status rose without start edge");

  a_start_slot: assert property (@(posedge ref_clk) disable iff (sys_rst)
    load |=> ((s_q.bit_q == sar_pkg::LAST_BIT)
              && (s_q.tick_q == 3'h0)))
    else $error("start did not reset the sequencer");

  // Checked through reset, so no disable clause here
  a_reset_clear: assert property (@(posedge ref_clk)
    sys_rst |=> (!status && (word_q == sar_pkg::IDLE_CODE)))
    else $error("reset left the converter busy");
endmodule

// ### rtl/sar_pkg.sv
package sar_pkg;
  localparam int          RES_BITS   = 16;
  localparam int          BIT_CNT_W  = 5;
  // Conversion must finish within this bound
  localparam int          CONV_MAX_NS = 35000;
  localparam int          CLK_NS      = 10;
  localparam int          CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
  // Cycles spent per bit decision, settling of the comparator
  localparam int          BIT_CYC     = 8;
  localparam int          BIT_CYC_W   = 3;
  localparam logic [15:0] START_CODE  = 16'h7FFF;
  localparam logic [15:0] IDLE_CODE   = 16'h0000;
  localparam logic [4:0]  LAST_BIT    = 5'h0F;
  localparam logic [2:0]  LAST_TICK   = 3'h7;

  typedef enum logic [1:0] {
    CODE_STRAIGHT = 2'h0,
    CODE_OFFSET   = 2'h1,
    CODE_TWOS     = 2'h2
  } coding_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } state_t;
endpackage

// ### rtl/sar_bit_reg.sv
// Successive-approximation register: holds trial/result word.
module sar_bit_reg (
  input  wire logic        ref_clk,   // System clock
  input  wire logic        sys_rst,   // Sync reset, high
  input  wire logic        load,      // Preset at start edge
  input  wire logic        step,      // Resolve current bit
  input  wire logic [3:0]  bit_idx,   // Bit under decision
  input  wire logic        keep,      // Comparator says keep bit
  output logic      [15:0] word_q     // Registered word
);
  logic [15:0] word_d;

  always_comb begin
    word_d = word_q;
    if (load) begin
      word_d = sar_pkg::START_CODE;
    end else if (step) begin
      word_d[bit_idx] = keep;
      if (bit_idx != 4'h0) begin
        word_d[bit_idx - 4'h1] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      word_q <= sar_pkg::IDLE_CODE;
    end else begin
      word_q <= word_d;
    end
  end
endmodule

// ### test/host_model.sv
// Host side: adapter start line, status sense, single 16-bit read
module host_model (
  input  wire logic        ref_clk,     // System clock
  input  wire logic        status,      // Converter busy
  input  wire logic        msb_true,    // Top bit, true form
  input  wire logic        msb_inv,     // Top bit, inverted form
  input  wire logic [14:0] data_low,    // Lower result bits
  output logic             convert_cmd  // Start line to converter
);
  timeunit 1ns;
  timeprecision 100ps;
  initial convert_cmd = 1'b0;
  // A second pulse mid-conversion mimics a careless host
  task automatic run(input bit twos, input bit again,
                     output logic [15:0] word, output int cyc);
    convert_cmd = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 convert_cmd = 1'b0;
    @(posedge ref_clk);
    #1 cyc = 0;
    while (status === 1'b1 && cyc < 4000) begin
      @(posedge ref_clk);
      #1 cyc++;
      if (again && cyc == 4) convert_cmd = 1'b1;
      if (again && cyc == 14) convert_cmd = 1'b0;
    end
    // Top bit takes the chosen form, the 15 lower bits come from data_low
    word = {twos ? msb_inv : msb_true, data_low};
  endtask
endmodule

// ### test/test_sar_adc_convert_and_output_coding.sv
module test_sar_adc_convert_and_output_coding;
  timeunit 1ns;
  timeprecision 100ps;
  logic             ref_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             cmp_keep = 1'b0;
  logic             convert_cmd, status, msb_true, msb_inv;
  logic [14:0]      data_low;
  logic [15:0]      trial_word, t0, w;
  logic [15:0]      ain = 16'h0000;
  logic [31:0]      rs = 32'h0000001C;
  logic [15:0]      cv [4] = '{16'hFFFF, 16'h8000, 16'h0000, 16'h7FFF};
  sar_pkg::coding_t coding_sel = sar_pkg::CODE_STRAIGHT;
  int               n_fail = 0;
  int               checks = 0;
  int               cyc;
  always #5 ref_clk = ~ref_clk;
  // Ideal comparator against the internal trial word
  // Trial holds the bit under test low with ones below it, so keep on >
  always @(posedge ref_clk) #1 cmp_keep = (ain > trial_word);
  always @(posedge status) #1 t0 = trial_word;
  sar_adc_ctrl i_sar_adc_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .convert_cmd(convert_cmd), .coding_sel(coding_sel),
    .cmp_keep(cmp_keep), .trial_word(trial_word), .status(status),
    .msb_true(msb_true), .msb_inv(msb_inv), .data_low(data_low));
  host_model i_host_model (.ref_clk(ref_clk), .status(status),
    .msb_true(msb_true), .msb_inv(msb_inv), .data_low(data_low),
    .convert_cmd(convert_cmd));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic conv(input logic [15:0] a, input int m, input bit rt);
    ain = a;
    t0 = 16'hXXXX;
    coding_sel = sar_pkg::coding_t'(m[1:0]);
    i_host_model.run(m == 2, rt, w, cyc);
    check(t0, sar_pkg::START_CODE);
    check(cyc[15:0], 16'h0080);
    check(w, m == 2 ? a ^ 16'h8000 : a);
    ain = ~a;
    repeat (20) @(posedge ref_clk);
    #1 check({msb_true, data_low}, a);
    check({msb_inv, data_low}, a ^ 16'h8000);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    check({13'h0000, status, msb_true, msb_inv}, 16'h0001);
    for (int m = 0; m < 3; m++) begin
      for (int i = 0; i < 4; i++) begin
        conv(cv[i], m, i == 1);
      end
    end
    repeat (12) begin
      rs = xs(rs);
      conv(rs[15:0], int'(rs[17:16]) % 3, rs[18]);
    end
    results();
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule
